// ===== modbus_slave_exception_scaler.sv
// modbus slave request checker, fieldbus scaler and response builder
//
// Operation
// - transfer integer equals engineering value times ten to the decimals
// - accepted write divides received integer by parameter scale before applying
// - successful request answered with the same function code
// - failed request answered with function code msb set
// - exception carries one error code byte after function code
// - code 01 for unsupported function or faulted drive
// - code 03 for disallowed request structure field value
// - code 04 for out-of-range or conflicting write value
// - code 05 for wrong password at verification address
// - code 06 for wrong frame length or crc mismatch
// - code 07 for write to read-only parameter, left unchanged
// - code 08 for run-locked parameter written while running
// - code 09 for any access but to the password address while password locks system
// - handled functions are 03 read, 06 write one, 10 write many
// - successful single write echoes the request frame
`timescale 1ns/1ps
`include "mb_exc_regs.svh"
module modbus_slave_exception_scaler
    import mb_exc_pkg::*;
#(
    // largest frame in bytes, crc included
    parameter int FRAME_MAX = 8,
    // highest register address the map accepts
    parameter logic [15:0] ADDR_LIMIT = 16'hffff
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clkEn,
    // parsed request with raw bytes for crc
    input wire logic reqValid,
    input wire mb_req_t req,
    input wire logic [8*FRAME_MAX-1:0] reqBytes,
    // parameter attributes from the parameter map
    input wire mb_param_t paramInfo,
    input wire logic addrOk,
    // drive state
    input wire logic driveFaulted,
    input wire logic driveRunning,
    input wire logic [15:0] userPassword,
    input wire logic [15:0] readData,
    // parameter write port, received integer and scale
    output logic paramWrite,
    output logic [15:0] paramAddr,
    output logic [15:0] paramInteger,
    output logic [15:0] paramScale,
    // response header
    output logic respValid,
    output logic [7:0] respSlave,
    output logic [7:0] respFunc,
    output logic [7:0] respErr,
    output logic [15:0] respWord1,
    output logic [15:0] respWord2,
    output logic [15:0] respCrc,
    output logic unlocked
);

    // scale is ten raised to the decimal count, held at 10000 for four decimals and up
    function automatic logic [15:0] scaleOf(input logic [3:0] dec);
        logic [15:0] s;
        s = 16'h0001;
        for (int i = 0; i < 4; i++) begin
            if (i < int'(dec)) begin
                s = 16'(s * 16'h000a);
            end
        end
        return s;
    endfunction : scaleOf

    // one byte step of the modbus crc-16
    function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int k = 0; k < 8; k++) begin
            r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : crcByte

    // sequencer state and captured request
    mb_state_t state_ff, nxt_state;
    mb_req_t req_ff, nxt_req;
    logic [8*FRAME_MAX-1:0] bytes_ff, nxt_bytes;
    logic [15:0] crc_ff, nxt_crc;
    logic [7:0] idx_ff, nxt_idx;
    logic [7:0] err_ff, nxt_err;
    logic unlocked_ff, nxt_unlocked;
    logic pwSet;
    logic isWrite;
    logic [7:0] crcLen;

    // a zero password means no lock is configured
    assign pwSet = (userPassword != 16'h0000);
    assign isWrite = (req_ff.func == `FC_WRITE1) || (req_ff.func == `FC_WRITEN);
    // crc covers all bytes but the two crc bytes
    assign crcLen = req_ff.frameLen - 8'h02;

    // sequencer: capture, crc, check, respond
    always_comb begin
        nxt_state = state_ff;
        nxt_req = req_ff;
        nxt_bytes = bytes_ff;
        nxt_crc = crc_ff;
        nxt_idx = idx_ff;
        nxt_err = err_ff;
        nxt_unlocked = unlocked_ff;
        unique case (state_ff)
            ST_IDLE: begin
                // a request offered while busy is dropped without notice
                if (reqValid) begin
                    nxt_req = req;
                    nxt_bytes = reqBytes;
                    nxt_crc = `CRC_INIT;
                    nxt_idx = 8'h00;
                    nxt_err = 8'h00;
                    nxt_state = ST_CRC;
                end
            end
            ST_CRC: begin
                // a length outside the legal window skips the crc walk
                // one byte per enabled cycle keeps the crc logic small
                if (req_ff.frameLen < 8'h04 || req_ff.frameLen > 8'(FRAME_MAX)) begin
                    nxt_state = ST_CHECK;
                end else if (idx_ff < crcLen) begin
                    nxt_crc = crcByte(crc_ff, bytes_ff[8*idx_ff +: 8]);
                    nxt_idx = idx_ff + 8'h01;
                end else begin
                    nxt_state = ST_CHECK;
                end
            end
            ST_CHECK: begin
                if (req_ff.frameLen < 8'h04 || req_ff.frameLen > 8'(FRAME_MAX)
                    || crc_ff != req_ff.crcRx) begin
                    nxt_err = `ERR_FRAME;
                end else if (!(req_ff.func == `FC_READ || isWrite) || driveFaulted) begin
                    nxt_err = `ERR_CMD;
                end else if (isWrite && req_ff.addr == `PWD_ADDR
                             && req_ff.value != userPassword) begin
                    nxt_err = `ERR_PWD;
                end else if (pwSet && !unlocked_ff && req_ff.addr != `PWD_ADDR) begin
                    nxt_err = `ERR_LOCKED;
                end else if (!addrOk || !paramInfo.valid
                             || 17'(req_ff.addr) + 17'(req_ff.qty) > 17'(ADDR_LIMIT) + 17'h1) begin
                    nxt_err = `ERR_ADDR;
                end else if (req_ff.func != `FC_WRITE1 && (req_ff.qty == 16'h0000
                             || req_ff.qty > `MAX_REGS || (req_ff.func == `FC_WRITEN
                             && req_ff.byteCnt != 8'(req_ff.qty << 1)))) begin
                    nxt_err = `ERR_DATA;
                end else if (isWrite && paramInfo.readOnly) begin
                    nxt_err = `ERR_RDONLY;
                end else if (isWrite && paramInfo.runLocked && driveRunning) begin
                    nxt_err = `ERR_RUNLOCK;
                end else if (isWrite && (!paramInfo.inRange || paramInfo.conflict)) begin
                    nxt_err = `ERR_RANGE;
                // clean write to the password address unlocks until reset
                end else if (isWrite && req_ff.addr == `PWD_ADDR) begin
                    nxt_unlocked = 1'b1;
                end
                nxt_state = ST_RESP;
            end
            ST_RESP: begin
                // outputs load from err_ff in this cycle
                nxt_state = ST_DONE;
            end
            ST_DONE: begin
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= ST_IDLE;
            req_ff <= '0;
            bytes_ff <= '0;
            crc_ff <= `CRC_INIT;
            idx_ff <= 8'h00;
            err_ff <= 8'h00;
            unlocked_ff <= 1'b0;
        end else if (clkEn) begin
            state_ff <= nxt_state;
            req_ff <= nxt_req;
            bytes_ff <= nxt_bytes;
            crc_ff <= nxt_crc;
            idx_ff <= nxt_idx;
            err_ff <= nxt_err;
            unlocked_ff <= nxt_unlocked;
        end
    end

    // response and write outputs
    logic nxt_paramWrite, nxt_respValid;
    logic [7:0] nxt_respFunc, nxt_respErr;
    logic [15:0] nxt_w1, nxt_w2, nxt_pAddr, nxt_pInt, nxt_pScale, nxt_respCrc;
    // running crc of the response bytes
    logic [15:0] c;
    always_comb begin
        c = `CRC_INIT;
        nxt_paramWrite = 1'b0;
        nxt_respValid = 1'b0;
        nxt_respFunc = respFunc;
        nxt_respErr = respErr;
        nxt_w1 = respWord1;
        nxt_w2 = respWord2;
        nxt_pAddr = paramAddr;
        nxt_pInt = paramInteger;
        nxt_pScale = paramScale;
        nxt_respCrc = respCrc;
        if (state_ff == ST_RESP) begin
            nxt_respValid = 1'b1;
            nxt_respErr = err_ff;
            if (err_ff != 8'h00) begin
                nxt_respFunc = req_ff.func | 8'h80;
                c = crcByte(c, req_ff.slave);
                c = crcByte(c, nxt_respFunc);
                c = crcByte(c, err_ff);
                nxt_w1 = 16'h0000;
                nxt_w2 = 16'h0000;
            end else begin
                nxt_respFunc = req_ff.func;
                nxt_w1 = req_ff.addr;
                nxt_w2 = (req_ff.func == `FC_READ) ? readData
                       : (req_ff.func == `FC_WRITE1) ? req_ff.value : req_ff.qty;
                c = crcByte(c, req_ff.slave);
                c = crcByte(c, req_ff.func);
                c = crcByte(c, nxt_w1[15:8]);
                c = crcByte(c, nxt_w1[7:0]);
                c = crcByte(c, nxt_w2[15:8]);
                c = crcByte(c, nxt_w2[7:0]);
                // only clean writes reach the parameter
                if (isWrite) begin
                    // integer over scale applied by the parameter store
                    nxt_paramWrite = 1'b1;
                    nxt_pAddr = req_ff.addr;
                    nxt_pInt = req_ff.value;
                    // scale is ten to the decimals, 10000 for four decimals and up
                    nxt_pScale = scaleOf(paramInfo.decimals);
                end
            end
            nxt_respCrc = c;
        end
    end

    // output registers
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            paramWrite <= 1'b0;
            paramAddr <= 16'h0000;
            paramInteger <= 16'h0000;
            paramScale <= 16'h0001;
            respValid <= 1'b0;
            respSlave <= 8'h00;
            respFunc <= 8'h00;
            respErr <= 8'h00;
            respWord1 <= 16'h0000;
            respWord2 <= 16'h0000;
            respCrc <= 16'h0000;
            unlocked <= 1'b0;
        end else if (clkEn) begin
            paramWrite <= nxt_paramWrite;
            paramAddr <= nxt_pAddr;
            paramInteger <= nxt_pInt;
            paramScale <= nxt_pScale;
            respValid <= nxt_respValid;
            respSlave <= req_ff.slave;
            respFunc <= nxt_respFunc;
            respErr <= nxt_respErr;
            respWord1 <= nxt_w1;
            respWord2 <= nxt_w2;
            respCrc <= nxt_respCrc;
            unlocked <= nxt_unlocked;
        end
    end

endmodule : modbus_slave_exception_scaler

// ===== mb_exc_regs.svh
// constants for the modbus request checker and response builder
`ifndef MB_EXC_REGS_SVH
`define MB_EXC_REGS_SVH
`define FC_READ 8'h03
`define FC_WRITE1 8'h06
`define FC_WRITEN 8'h10
`define EXC_BIT 7
`define ERR_CMD 8'h01
`define ERR_ADDR 8'h02
`define ERR_DATA 8'h03
`define ERR_RANGE 8'h04
`define ERR_PWD 8'h05
`define ERR_FRAME 8'h06
`define ERR_RDONLY 8'h07
`define ERR_RUNLOCK 8'h08
`define ERR_LOCKED 8'h09
`define CRC_INIT 16'hffff
`define CRC_POLY 16'ha001
`define PWD_ADDR 16'h0700
`define MAX_REGS 16'h007d
`endif

// ===== mb_exc_pkg.sv
// types for the modbus request checker and response builder
package mb_exc_pkg;
    typedef struct packed {
        logic [7:0] slave;
        logic [7:0] func;
        logic [15:0] addr;
        logic [15:0] qty;
        logic [7:0] byteCnt;
        logic [15:0] value;
        logic [15:0] crcRx;
        logic [7:0] frameLen;
    } mb_req_t;
    typedef struct packed {
        logic readOnly;
        logic runLocked;
        logic inRange;
        logic conflict;
        logic valid;
        logic [3:0] decimals;
    } mb_param_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CRC = 3'b001,
        ST_CHECK = 3'b011,
        ST_RESP = 3'b010,
        ST_DONE = 3'b110
    } mb_state_t;
endpackage : mb_exc_pkg

// ===== mb_exc_props.sv
// assertions on the modbus request checker ports
`timescale 1ns/1ps
module mb_exc_props
    import mb_exc_pkg::*;
(
    // clock, reset and request
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire logic reqValid,
    input wire mb_req_t req,
    // results
    input wire logic paramWrite,
    input wire logic [15:0] paramScale,
    input wire logic respValid,
    input wire logic [7:0] respFunc,
    input wire logic [7:0] respErr,
    input wire logic [15:0] respWord1,
    input wire logic [15:0] respWord2,
    input wire logic unlocked
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    logic busy_ff;
    logic nxt_busy;
    logic [7:0] func_ff;
    logic [7:0] nxt_func;
    // request in flight and its function code
    always_comb begin
        nxt_busy = busy_ff & ~respValid;
        nxt_func = func_ff;
        if (clkEn && reqValid && !busy_ff) begin
            nxt_busy = 1'b1;
            nxt_func = req.func;
        end
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            busy_ff <= 1'b0;
            func_ff <= 8'h00;
        end else begin
            busy_ff <= nxt_busy;
            func_ff <= nxt_func;
        end
    end
    sequence s_take;
        clkEn && reqValid && !busy_ff;
    endsequence
    sequence s_exc;
        respValid && respErr != 8'h00;
    endsequence
    sequence s_ok;
        respValid && respErr == 8'h00;
    endsequence
    a_ok_func: assert property (s_ok |-> respFunc == func_ff)
        else $error("normal function code wrong");
    a_exc_func: assert property (s_exc |-> respFunc == (func_ff | 8'h80))
        else $error("exception function code wrong");
    a_exc_words: assert property (s_exc |-> respWord1 == 16'h0 && respWord2 == 16'h0)
        else $error("exception carries data");
    a_err_range: assert property (respValid |-> respErr <= 8'h09)
        else $error("error code out of set");
    a_write_ok: assert property (paramWrite |-> s_ok)
        else $error("write without clean response");
    a_scale_pow: assert property (paramWrite |-> paramScale inside {1, 10, 100, 1000, 10000})
        else $error("scale not a power of ten");
    a_resp_pulse: assert property (respValid && clkEn |=> !respValid)
        else $error("response longer than a pulse");
    a_resp_bound: assert property (s_take |-> ##[1:80] respValid)
        else $error("no response in time");
    a_unlock_hold: assert property (unlocked |=> unlocked)
        else $error("unlock dropped");
endmodule : mb_exc_props

// ===== mb_master_model.sv
// modbus master model that frames requests with crc
`timescale 1ns/1ps
module mb_master_model
    import mb_exc_pkg::*;
(
    // fields chosen by the bench
    input wire logic [7:0] func,
    input wire logic [15:0] addr,
    input wire logic [15:0] qty,
    input wire logic [15:0] value,
    input wire logic badCrc,
    input wire logic badLen,
    // frame offered to the slave
    output mb_req_t req,
    output logic [95:0] frame
);
    logic [95:0] body;
    logic [15:0] crc;
    int len;
    function automatic logic [15:0] crc16(input logic [95:0] f, input int n);
        logic [15:0] c;
        c = 16'hffff;
        for (int i = 0; i < n; i++) begin
            c ^= {8'h00, f[8*i+:8]};
            for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction : crc16
    // frame layout and crc, optionally spoilt
    always_comb begin
        body = {64'h0, addr[7:0], addr[15:8], func, 8'h01};
        len = 9;
        if (func == 8'h10) body[71:32] = {value[7:0], value[15:8], qty[6:0], 1'b0, qty[7:0], qty[15:8]};
        else len = 6;
        if (func == 8'h06) body[47:32] = {value[7:0], value[15:8]};
        else if (func != 8'h10) body[47:32] = {qty[7:0], qty[15:8]};
        crc = crc16(body, len) ^ {15'h0, badCrc};
        frame = body | ({80'h0, crc} << (8 * len));
        req = '{8'h01, func, addr, qty, {qty[6:0], 1'b0}, value, crc, 8'(len + 2 - badLen)};
    end
endmodule : mb_master_model

// ===== tb_top.sv
// self-checking bench for the modbus request checker
`timescale 1ns/1ps
module tb_top
    import mb_exc_pkg::*;
;
    logic clk_sys = 0, reset_n = 0, clkEn = 1, reqValid = 0, addrOk, faulted, running;
    logic badCrc, badLen, unl = 0;
    logic [7:0] func;
    logic [15:0] addr, qty, value, pwd = 16'h0, readData = 16'h0;
    logic [31:0] rnd = 32'h0f05;
    mb_param_t pi;
    mb_req_t req;
    logic [95:0] frame;
    logic paramWrite, respValid, unlocked;
    logic [15:0] paramAddr, paramInteger, paramScale, respWord1, respWord2, respCrc;
    logic [7:0] respSlave, respFunc, respErr;
    int fail_count = 0, n_checks = 0, cycles = 0;
    always #2 clk_sys = ~clk_sys;
    mb_master_model u_mst (.func, .addr, .qty, .value, .badCrc, .badLen, .req, .frame);
    modbus_slave_exception_scaler #(.FRAME_MAX(12)) u_dut (.clk_sys, .reset_n, .clkEn,
        .reqValid, .req, .reqBytes(frame), .paramInfo(pi), .addrOk, .driveFaulted(faulted),
        .driveRunning(running), .userPassword(pwd), .readData, .paramWrite, .paramAddr,
        .paramInteger, .paramScale, .respValid, .respSlave, .respFunc, .respErr,
        .respWord1, .respWord2, .respCrc, .unlocked);
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : final_report
    task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (e !== g) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : check
    // lfsr step for repeatable stimulus
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], 1'b0} ^ (v[31] ? 32'h04c11db7 : 32'h0);
    endfunction : lfsr
    task automatic step();
        rnd = lfsr(rnd);
    endtask : step
    // modbus crc-16 over the first n bytes, byte 0 lowest
    function automatic logic [15:0] crc16(input logic [95:0] f, input int n);
        logic [15:0] c;
        c = 16'hffff;
        for (int i = 0; i < n; i++) begin
            c ^= {8'h00, f[8*i+:8]};
            for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction : crc16
    // expected error code in the slave's priority order
    function automatic logic [7:0] exp_err();
        logic wr;
        wr = func != 8'h03;
        if (badCrc || badLen) return 8'h06;
        if (!(func inside {8'h03, 8'h06, 8'h10}) || faulted) return 8'h01;
        if (wr && addr == 16'h0700 && value != pwd) return 8'h05;
        if (pwd != 16'h0 && !unl && addr != 16'h0700) return 8'h09;
        if (!addrOk) return 8'h02;
        if (func != 8'h06 && (qty == 16'h0 || qty > 16'h007d)) return 8'h03;
        if (wr && pi.readOnly) return 8'h07;
        if (wr && pi.runLocked && running) return 8'h08;
        if (wr && (!pi.inRange || pi.conflict)) return 8'h04;
        return 8'h00;
    endfunction : exp_err
    task automatic do_req();
        logic [7:0] e, f;
        logic w;
        logic [15:0] w1, w2, sc, ec;
        int n;
        e = exp_err();
        f = e != 8'h0 ? func | 8'h80 : func;
        // a clean write lands in the store, the password address included
        w = e == 8'h0 && func != 8'h03;
        w1 = e != 8'h0 ? 16'h0 : addr;
        w2 = e != 8'h0 ? 16'h0 : func == 8'h03 ? readData : func == 8'h06 ? value : qty;
        sc = 16'(10 ** pi.decimals);
        ec = e != 8'h0 ? crc16({72'h0, e, f, 8'h01}, 3)
            : crc16({48'h0, w2[7:0], w2[15:8], w1[7:0], w1[15:8], f, 8'h01}, 6);
        @(posedge clk_sys) #1 reqValid = 1;
        @(posedge clk_sys) #1 reqValid = 0;
        n = 0;
        while (respValid !== 1'b1 && n < 200) begin
            step();
            clkEn = rnd[1:0] != 2'b00;
            @(posedge clk_sys) #1 n++;
        end
        clkEn = 1;
        if (n >= 200) begin
            fail_count++;
            $display("Error respValid expected 1 seen %b", respValid);
        end
        if (w && addr == 16'h0700) unl = 1;
        check("func", {8'h0, f}, {8'h0, respFunc});
        check("err", {8'h0, e}, {8'h0, respErr});
        check("write", {15'h0, w}, {15'h0, paramWrite});
        check("unlock", {15'h0, unl}, {15'h0, unlocked});
        check("crc", ec, respCrc);
        check("slave", 16'h0001, {8'h0, respSlave});
        check("word1", w1, respWord1);
        check("word2", w2, respWord2);
        if (w) check("scale", sc, paramScale);
        if (w) check("addr", addr, paramAddr);
        if (e == 8'h0 && func == 8'h03) check("eng", readData / sc, respWord2 / sc);
        if (w) check("integer", value, paramInteger);
        if (w && func == 8'h06) check("echo", req.crcRx, respCrc);
        repeat (2) @(posedge clk_sys);
        #1 n = 0;
    endtask : do_req
    task automatic corner(input logic [7:0] f, input logic [15:0] q, input int k);
        {func, addr, qty, value, addrOk, faulted, running, badCrc, badLen} = {f, 16'h10, q,
            16'h5, 5'b10000};
        pi = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 4'h2};
        case (k)
            1: badCrc = 1;
            2: {pi.readOnly, badLen} = 2'b11;
            3: faulted = 1;
            4: addrOk = 0;
            5: pi.readOnly = 1;
            6: {pi.runLocked, running} = 2'b11;
            7: pi.conflict = 1;
            8: pi.inRange = 0;
            9: addr = 16'h0700;
            10: {addr, value} = {16'h0700, pwd};
            default: ;
        endcase
        do_req();
    endtask : corner
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            final_report();
        end
    end
    initial begin
        repeat (2) @(posedge clk_sys);
        #1 reset_n = 1;
        corner(8'h06, 16'h1, 0);
        for (int k = 0; k < 9; k++) corner(k[0] ? 8'h06 : 8'h10, 16'h1, k);
        corner(8'h03, 16'h007d, 0);
        corner(8'h03, 16'h007e, 0);
        corner(8'h2b, 16'h1, 0);
        pwd = 16'h1234;
        corner(8'h03, 16'h1, 0);
        corner(8'h06, 16'h1, 9);
        corner(8'h06, 16'h1, 10);
        corner(8'h03, 16'h1, 0);
        repeat (200) begin
            step();
            func = rnd[1:0] == 2'b11 ? 8'h2b : rnd[1] ? 8'h10 : rnd[0] ? 8'h06 : 8'h03;
            addr = {8'h00, rnd[11:4]};
            qty = func == 8'h03 ? {9'h0, rnd[22:16]} : 16'h1;
            pi = '{&rnd[24:23], rnd[25], |rnd[27:26], &rnd[29:28], 1'b1, 4'(rnd[31:29] % 5)};
            step();
            {value, readData} = rnd;
            step();
            {addrOk, running, faulted, badCrc, badLen} = {|rnd[2:0], rnd[3], ~|rnd[7:4],
                ~|rnd[11:8], ~|rnd[15:12]};
            do_req();
        end
        // mid-run reset drops the sticky unlock
        reset_n = 0;
        @(posedge clk_sys) #1 reset_n = 1;
        unl = 0;
        check("reset", 16'h0, {14'h0, respValid, unlocked});
        corner(8'h03, 16'h1, 0);
        final_report();
    end
endmodule : tb_top
bind modbus_slave_exception_scaler mb_exc_props u_props (.clk_sys, .reset_n, .clkEn,
    .reqValid, .req, .paramWrite, .paramScale, .respValid, .respFunc, .respErr,
    .respWord1, .respWord2, .unlocked);
